// File: dv/dcc_mem_model.sv
/* Memory and peripheral model on the system bus side of the channel.
   Assumes one access at a time; grant follows request one cycle late. */
`timescale 1ns/10ps
module dcc_mem_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic slow,
    input wire logic bus_req,
    output logic bus_gnt,
    input wire logic mst_req,
    input wire logic [31:0] mst_addr,
    output logic [31:0] mst_rdata,
    output logic mst_ack
);
    // ----
    // Grant and acknowledge
    // ----
    logic [1:0] wait_r;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bus_gnt <= 1'b0;
            wait_r <= 2'h0;
            mst_ack <= 1'b0;
            mst_rdata <= 32'h0;
        end else begin
            bus_gnt <= bus_req;
            mst_ack <= 1'b0;
            // Data is only valid with the acknowledge; otherwise it toggles.
            mst_rdata <= ~mst_rdata;
            if (mst_req && !mst_ack) begin
                if (wait_r == (slow ? 2'h3 : 2'h0)) begin
                    mst_ack <= 1'b1;
                    mst_rdata <= {~mst_addr[15:0], mst_addr[15:0]};
                    wait_r <= 2'h0;
                end else begin
                    wait_r <= wait_r + 2'h1;
                end
            end
        end
    end
endmodule

// File: dv/dcc_props.sv
/* Checker of the DMA channel control block, bound to its top module.
   Assumes one clock CLK and the asynchronous active-low reset RST_B. */
`timescale 1ns/10ps
module dcc_props (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic HSEL,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    input wire logic BUS_REQ,
    input wire logic BUS_GNT,
    input wire logic MST_REQ,
    input wire logic MST_WRITE,
    input wire logic [31:0] MST_ADDR,
    input wire logic [3:0] MST_BE,
    input wire logic [31:0] MST_WDATA,
    input wire logic [31:0] MST_RDATA,
    input wire logic MST_ACK
);
    // ----
    // Read data phase tracking
    // ----
    logic rd_ph_r;
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) rd_ph_r <= 1'b0;
        else rd_ph_r <= HSEL && HTRANS[1] && HREADY && !HWRITE;
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);
    sequence s_rd_done;
        MST_REQ && !MST_WRITE && MST_ACK;
    endsequence
    sequence s_wr_beat;
        MST_REQ && MST_WRITE;
    endsequence
    sequence s_wr_ack;
        MST_REQ && MST_WRITE && MST_ACK;
    endsequence
    property p_bus_ok;
        HREADYOUT && !HRESP;
    endproperty
    a_bus_ok: assert property (p_bus_ok) else $error("register bus stalled or errored");
    property p_rd_idle;
        !rd_ph_r |-> HRDATA == 32'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside a read data phase");
    property p_hold;
        MST_REQ && !MST_ACK |=> MST_REQ && $stable(MST_ADDR) && $stable(MST_BE) && $stable(MST_WRITE);
    endproperty
    a_hold: assert property (p_hold) else $error("access changed before acknowledge");
    property p_fell;
        $fell(MST_REQ) |-> $past(MST_ACK);
    endproperty
    a_fell: assert property (p_fell) else $error("access dropped without acknowledge");
    property p_wdata;
        s_rd_done ##1 s_wr_beat |-> MST_WDATA == $past(MST_RDATA);
    endproperty
    a_wdata: assert property (p_wdata) else $error("write data differs from word read");
    property p_wr_once;
        s_wr_ack |=> !MST_WRITE;
    endproperty
    a_wr_once: assert property (p_wr_once) else $error("write beat repeated");
    property p_idle;
        !MST_REQ |-> MST_ADDR == 32'h0 && MST_BE == 4'h0 && !MST_WRITE;
    endproperty
    a_idle: assert property (p_idle) else $error("access outputs active while idle");
    property p_req_bus;
        MST_REQ |-> BUS_REQ;
    endproperty
    a_req_bus: assert property (p_req_bus) else $error("access without bus request");
    property p_gnt;
        $rose(MST_REQ) |-> $past(BUS_GNT);
    endproperty
    a_gnt: assert property (p_gnt) else $error("access started without grant");
endmodule
bind dcc_channel dcc_props u_props (.CLK, .RST_B, .HSEL, .HTRANS, .HWRITE, .HREADY, .HRDATA, .HREADYOUT, .HRESP,
    .BUS_REQ, .BUS_GNT, .MST_REQ, .MST_WRITE, .MST_ADDR, .MST_BE, .MST_WDATA, .MST_RDATA, .MST_ACK);

// File: dv/testbench.sv
/* Self-checking testbench of the DMA channel control block.
   Assumes the design, the memory model and the checker compiled first. */
`timescale 1ns/10ps
module testbench;
    logic CLK, RST_B, HSEL, HWRITE, DMA_IRQ, slow;
    logic [1:0] HTRANS;
    logic [31:0] HADDR, HWDATA, HRDATA, MST_ADDR, MST_WDATA, MST_RDATA;
    logic HREADYOUT, HRESP, BUS_REQ, BUS_GNT, MST_REQ, MST_WRITE, MST_ACK;
    logic [3:0] MST_BE;
    logic [31:0] es, et, nxt_s, nxt_t, ra, d, s, t;
    logic [15:0] lo, l, h;
    int failures, total_checks, nb, beat, xfers, swap_at, n;
    int seed = 12808;
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin failures++; $display("Error %0t: %h not %h", $time, g, e); end end
    dcc_channel dut (.CLK, .RST_B, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE(3'h2), .HWDATA, .HREADY(HREADYOUT),
        .HRDATA, .HREADYOUT, .HRESP, .DMA_IRQ, .BUS_REQ, .BUS_GNT, .MST_REQ, .MST_WRITE, .MST_ADDR, .MST_BE,
        .MST_WDATA, .MST_RDATA, .MST_ACK);
    dcc_mem_model mem (.clk(CLK), .rst_b(RST_B), .slow, .bus_req(BUS_REQ), .bus_gnt(BUS_GNT),
        .mst_req(MST_REQ), .mst_addr(MST_ADDR), .mst_rdata(MST_RDATA), .mst_ack(MST_ACK));
    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end
    // ----
    // Expectations and bus tasks
    // ----
    function automatic logic [3:0] exp_be(input logic [1:0] w, input logic [1:0] a, input logic big);
        if (w == 2'h0) return 4'h1 << (big ? 2'h3 - a : a);
        if (w == 2'h1) return (a[1] ^ big) ? 4'hC : 4'h3;
        return 4'hF;
    endfunction
    function automatic logic [31:0] stp(input logic b, input logic [1:0] w);
        return b ? 32'(4 * nb) : (w == 2'h3 ? 32'h4 : {30'h0, w} + 32'h1);
    endfunction
    task automatic end_sim;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic tmo(input int k);
        if (k > 3000) begin
            failures++;
            $display("Error %0t: timeout", $time);
            end_sim();
        end
    endtask
    task automatic rdy;
        n = 0;
        @(posedge CLK);
        while (HREADYOUT !== 1'b1) begin
            tmo(n++);
            @(posedge CLK);
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] v);
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HADDR <= {24'h0, a};
        HWRITE <= w;
        rdy();
        HTRANS <= 2'h0;
        HSEL <= 1'b0;
        HWDATA <= v;
        rdy();
        d = HRDATA;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        `CHK(d, e)
    endtask
    task automatic wait_x(input int k);
        n = 0;
        while (xfers < k) begin
            @(posedge CLK);
            tmo(n++);
        end
        repeat (8) @(posedge CLK);
    endtask
    task automatic wgnt(input logic v);
        n = 0;
        do begin
            @(posedge CLK);
            tmo(n++);
        end while (BUS_GNT !== v);
    endtask
    task automatic run(input logic [15:0] x, input logic [15:0] y, input logic [31:0] c);
        lo = x;
        es = s;
        et = t;
        beat = 0;
        xfers = 0;
        nb = !x[9] ? 1 : (y[3:0] == 4'h0 ? 4 : int'(y[3:0]));
        ahb(1'b1, 8'h00, {16'h0, x});
        ahb(1'b1, 8'h08, s);
        ahb(1'b1, 8'h0C, t);
        ahb(1'b1, 8'h10, c);
        ahb(1'b1, 8'h04, {16'h0, y});
    endtask
    // ----
    // Monitor of system bus accesses
    // ----
    always @(posedge CLK) begin
        if (MST_REQ && MST_ACK && !MST_WRITE) begin
            ra = es + 32'(4 * beat);
            `CHK(MST_ADDR, ra)
            `CHK(MST_BE, lo[9] ? 4'hF : exp_be(lo[7:6], es[1:0], lo[3]))
        end
        if (MST_REQ && MST_ACK && MST_WRITE) begin
            `CHK(MST_ADDR, et + 32'(4 * beat))
            `CHK(MST_BE, lo[9] ? 4'hF : exp_be(lo[5:4], et[1:0], lo[2]))
            `CHK(MST_WDATA, {~ra[15:0], ra[15:0]})
            beat++;
            if (beat == nb) begin
                beat = 0;
                xfers++;
                es = es + (lo[1] ? stp(lo[9], lo[7:6]) : 32'h0);
                et = et + (lo[0] ? stp(lo[9], lo[5:4]) : 32'h0);
                if (xfers == swap_at) begin
                    es = nxt_s;
                    et = nxt_t;
                end
            end
        end
    end
    // ----
    // Main sequence
    // ----
    initial begin
        {RST_B, HSEL, HWRITE, DMA_IRQ, slow, HTRANS, HADDR, HWDATA} = '0;
        {failures, total_checks, beat, xfers, swap_at} = '0;
        {es, et, ra, s, t, lo} = '0;
        nb = 1;
        repeat (12) @(posedge CLK);
        RST_B <= 1'b1;
        rc(8'h00, 32'h0);
        rc(8'h04, 32'hFF00);
        rc(8'h14, 32'h4);
        ahb(1'b1, 8'h20, 32'hFFFFFFFF);
        rc(8'h20, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 12; i++) begin
            l = 16'($random(seed)) & 16'h02FF;
            l[7] = l[7] & l[6];
            l[5] = l[5] & l[4];
            h = 16'h7F00 | 16'(i % 4);
            slow <= i[2];
            s = $random(seed) & {30'h3FFFFFFF, ~(l[7] | l[9]), ~(l[6] | l[9])};
            t = $random(seed) & {30'h3FFFFFFF, ~(l[5] | l[9]), ~(l[4] | l[9])};
            run(l, h, 32'h3);
            wait_x(3);
            rc(8'h10, 32'h0);
            rc(8'h08, es);
            rc(8'h0C, et);
        end
        $display("test transfers done");
        s = 32'h100;
        t = 32'h200;
        DMA_IRQ <= 1'b1;
        run(16'h10F3, 16'h7F00, 32'h2);
        wgnt(1'b1);
        wgnt(1'b0);
        DMA_IRQ <= 1'b0;
        repeat (30) @(posedge CLK);
        `CHK(xfers, 1)
        DMA_IRQ <= 1'b1;
        @(posedge CLK);
        DMA_IRQ <= 1'b0;
        wait_x(2);
        $display("test wait mode done");
        slow <= 1'b1;
        s = 32'h300;
        t = 32'h400;
        run(16'h00F3, 16'h7F00, 32'h6);
        wait_x(1);
        ahb(1'b1, 8'h04, 32'hFF00);
        n = xfers;
        repeat (40) @(posedge CLK);
        `CHK(xfers <= n + 1, 1'b1)
        rc(8'h14, 32'h100);
        ahb(1'b0, 8'h10, 32'h0);
        `CHK(d, 32'h5)
        $display("test halt done");
        slow <= 1'b0;
        for (int k = 0; k < 4; k++) begin
            for (int j = 0; j < 4; j++) begin
                ahb(1'b1, 8'(8'h40 + 16 * j), 32'h7F0000F3);
                ahb(1'b1, 8'(8'h44 + 16 * j), 32'(32'h1000 * (j + 1)));
                ahb(1'b1, 8'(8'h48 + 16 * j), 32'(32'h8000 * (j + 1)));
                ahb(1'b1, 8'(8'h4C + 16 * j), 32'h1);
            end
            nxt_s = 32'(32'h1000 * (k + 1));
            nxt_t = 32'(32'h8000 * (k + 1));
            swap_at = 1;
            s = 32'h500;
            t = 32'h600;
            run(16'h00F3, {6'h0, 2'(k), 8'h00}, 32'h1);
            wait_x(2);
            rc(8'h08, es);
        end
        $display("test chaining done");
        end_sim();
    end
endmodule

// File: hw/dcc_channel.sv
/*
 * One internal DMA channel: AHB-Lite register slave, link descriptor chaining, transfer engine.
 * Assumes a single-master system bus with grant, and a request/acknowledge memory port.
 */
// The register addresses and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "dcc_defines.svh"

// Notes on behaviour
// - In wait mode, interrupt is sampled only from the clock after grant release.
// - Pacing bit 12 set waits for an interrupt per transfer; 0 runs back to back.
// - Bit 9 selects burst transactions using the length code, else single accesses.
// - Source width bits 7:6 with address and byte order form source byte enables of single accesses; bursts enable all four lanes.
// - Target width bits 5:4 with address and byte order form target byte enables of single accesses; bursts enable all four lanes.
// - Source byte order bit 3: one big endian, zero little endian.
// - Target byte order bit 2: one big endian, zero little endian.
// - Bit 1 advances source address after transactions; zero holds it.
// - Bit 0 advances target address after transactions; zero holds it.
// - Halt bit 15 resets set, stops at once, lets current bus access finish.
// - Chain end bit 14 resets set and stops at chain end; zero continues.
// - Software writes reserved link bits all ones or all zeros with chain end.
// - Link select 3,2,1,0 loads descriptor d,c,b,a when the count reaches zero.
// - Length code applies only in burst style; code 0 gives four words.
// - Count drops by one per transaction; zero goes straight to the next link.
// - Addresses advance by their transaction size when increment bits allow.
module dcc_channel (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic DMA_IRQ,
    output logic BUS_REQ,
    input wire logic BUS_GNT,
    output logic MST_REQ,
    output logic MST_WRITE,
    output logic [31:0] MST_ADDR,
    output logic [3:0] MST_BE,
    output logic [31:0] MST_WDATA,
    input wire logic [31:0] MST_RDATA,
    input wire logic MST_ACK
);
    import dcc_pkg::*;

    function automatic logic is_link(input logic [7:0] a);
        is_link = (a[7:6] == `DCC_LINK_AREA);
    endfunction

    dcc_state_t state_r;
    logic [15:0] ctl_lo_r;
    logic [15:0] ctl_hi_r;
    logic [31:0] src_r;
    logic [31:0] tgt_r;
    logic [31:0] cnt_r;
    logic [31:0] data_r;
    logic [3:0] beat_r;
    logic gnt_q;
    logic [1:0] ld_link_r;
    logic [2:0] ld_idx_r;
    logic ld_vld_q;
    logic [1:0] ld_word_q;
    logic wr_q;
    logic mem_q;
    logic [7:0] addr_q;
    logic [31:0] rd_r;
    logic [31:0] rd_val;
    logic [31:0] mem_rdata;
    logic [3:0] mem_raddr;
    logic addr_ph;
    logic bus_mem_rd;
    logic ld_iss;
    logic halt;
    logic irq_ok;
    logic [3:0] beats;
    logic last_beat;
    logic [31:0] beat_ofs;
    logic [31:0] src_step;
    logic [31:0] tgt_step;
    logic [3:0] src_be;
    logic [3:0] tgt_be;

    // ----------------------------------------------------------------
    // Register bus slave
    // ----------------------------------------------------------------
    assign addr_ph = HSEL && HTRANS[1] && HREADY;
    assign bus_mem_rd = addr_ph && !HWRITE && is_link(HADDR[7:0]);
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign HRDATA = mem_q ? mem_rdata : rd_r;

    always_comb begin
        case (HADDR[7:0])
            `DCC_OFS_CTL_LO: rd_val = {16'h0000, ctl_lo_r};
            `DCC_OFS_CTL_HI: rd_val = {16'h0000, ctl_hi_r};
            `DCC_OFS_SRC: rd_val = src_r;
            `DCC_OFS_TGT: rd_val = tgt_r;
            `DCC_OFS_CNT: rd_val = cnt_r;
            `DCC_OFS_STAT: rd_val = {20'h00000, beat_r, 1'b0, state_r, 1'b0,
                (state_r == DCC_IDLE && cnt_r == 32'h0 && ctl_hi_r[`DCC_HI_END]),
                (state_r == DCC_WAIT), (state_r != DCC_IDLE)};
            default: rd_val = 32'h00000000;
        endcase
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            wr_q <= 1'b0;
            mem_q <= 1'b0;
            addr_q <= 8'h00;
            rd_r <= 32'h00000000;
        end else begin
            wr_q <= addr_ph && HWRITE;
            mem_q <= bus_mem_rd;
            if (addr_ph) begin
                addr_q <= HADDR[7:0];
            end
            rd_r <= (addr_ph && !HWRITE) ? rd_val : 32'h00000000;
        end
    end

    // ----------------------------------------------------------------
    // Link descriptor storage
    // ----------------------------------------------------------------
    assign ld_iss = (state_r == DCC_LOAD) && !ld_idx_r[2] && !bus_mem_rd;
    assign mem_raddr = bus_mem_rd ? HADDR[5:2] : {ld_link_r, ld_idx_r[1:0]};

    dcc_link_mem u_mem (
        .CLK(CLK),
        .we(wr_q && is_link(addr_q)),
        .waddr(addr_q[5:2]),
        .wdata(HWDATA),
        .raddr(mem_raddr),
        .rdata(mem_rdata)
    );

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            ld_link_r <= 2'h0;
            ld_idx_r <= 3'h0;
            ld_vld_q <= 1'b0;
            ld_word_q <= 2'h0;
        end else begin
            ld_vld_q <= ld_iss;
            ld_word_q <= ld_idx_r[1:0];
            if (state_r != DCC_LOAD) begin
                ld_link_r <= ctl_hi_r[`DCC_HI_LINK];
                ld_idx_r <= 3'h0;
            end else if (ld_iss) begin
                ld_idx_r <= ld_idx_r + 3'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    // Reserved link bits are kept as written; software keeps them equal to chain end.
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            ctl_lo_r <= `DCC_CTL_LO_RST;
            ctl_hi_r <= `DCC_CTL_HI_RST;
        end else begin
            if (ld_vld_q && ld_word_q == 2'h0) begin
                ctl_lo_r <= mem_rdata[15:0];
                ctl_hi_r <= mem_rdata[31:16];
            end
            if (wr_q && addr_q == `DCC_OFS_CTL_LO) begin
                ctl_lo_r <= HWDATA[15:0];
            end
            if (wr_q && addr_q == `DCC_OFS_CTL_HI) begin
                ctl_hi_r <= HWDATA[15:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Transaction sizing
    // ----------------------------------------------------------------
    assign halt = ctl_hi_r[`DCC_HI_HALT];
    assign irq_ok = !BUS_GNT && !gnt_q;

    always_comb begin
        if (!ctl_lo_r[`DCC_LO_BURST]) begin
            beats = 4'h1;
        end else if (ctl_hi_r[`DCC_HI_LEN] == `DCC_LEN_CODE_DEF) begin
            beats = `DCC_BEATS_DEF;
        end else begin
            beats = ctl_hi_r[`DCC_HI_LEN];
        end
    end

    assign last_beat = (beat_r == beats - 4'h1);
    assign beat_ofs = {26'h0, beat_r, 2'h0};

    always_comb begin
        if (ctl_lo_r[`DCC_LO_BURST]) begin
            src_step = {26'h0, beats, 2'h0};
            tgt_step = {26'h0, beats, 2'h0};
        end else begin
            case (dcc_width_t'(ctl_lo_r[`DCC_LO_SW]))
                DCC_W_BYTE: src_step = 32'h1;
                DCC_W_HALF: src_step = 32'h2;
                DCC_W_WORD: src_step = 32'h4;
                default: src_step = 32'h0;
            endcase
            case (dcc_width_t'(ctl_lo_r[`DCC_LO_TW]))
                DCC_W_BYTE: tgt_step = 32'h1;
                DCC_W_HALF: tgt_step = 32'h2;
                DCC_W_WORD: tgt_step = 32'h4;
                default: tgt_step = 32'h0;
            endcase
        end
    end

    dcc_lane_enable u_src_be (
        .width(dcc_width_t'(ctl_lo_r[`DCC_LO_SW])),
        .addr(src_r[1:0]),
        .big(ctl_lo_r[`DCC_LO_SBIG]),
        .be(src_be)
    );

    dcc_lane_enable u_tgt_be (
        .width(dcc_width_t'(ctl_lo_r[`DCC_LO_TW])),
        .addr(tgt_r[1:0]),
        .big(ctl_lo_r[`DCC_LO_TBIG]),
        .be(tgt_be)
    );

    // ----------------------------------------------------------------
    // Channel sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            state_r <= DCC_IDLE;
        end else begin
            case (state_r)
                DCC_IDLE: begin
                    if (!halt) begin
                        if (cnt_r == 32'h0) begin
                            if (!ctl_hi_r[`DCC_HI_END]) begin
                                state_r <= DCC_LOAD;
                            end
                        end else if (ctl_lo_r[`DCC_LO_WINT]) begin
                            state_r <= DCC_WAIT;
                        end else begin
                            state_r <= DCC_REQ;
                        end
                    end
                end
                DCC_WAIT: begin
                    if (halt) begin
                        state_r <= DCC_IDLE;
                    end else if (irq_ok && DMA_IRQ) begin
                        state_r <= DCC_REQ;
                    end
                end
                DCC_REQ: begin
                    if (halt) begin
                        state_r <= DCC_IDLE;
                    end else if (BUS_GNT) begin
                        state_r <= DCC_RD;
                    end
                end
                DCC_RD: begin
                    if (MST_ACK) begin
                        state_r <= halt ? DCC_IDLE : DCC_WR;
                    end
                end
                DCC_WR: begin
                    if (MST_ACK) begin
                        if (halt) begin
                            state_r <= DCC_IDLE;
                        end else if (last_beat) begin
                            state_r <= DCC_STEP;
                        end else begin
                            state_r <= DCC_RD;
                        end
                    end
                end
                DCC_STEP: state_r <= DCC_IDLE;
                DCC_LOAD: begin
                    if (halt || (ld_vld_q && ld_word_q == `DCC_LD_LAST)) begin
                        state_r <= DCC_IDLE;
                    end
                end
                default: state_r <= DCC_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            gnt_q <= 1'b0;
            beat_r <= 4'h0;
            data_r <= 32'h00000000;
        end else begin
            gnt_q <= BUS_GNT;
            if (state_r == DCC_REQ) begin
                beat_r <= 4'h0;
            end else if (state_r == DCC_WR && MST_ACK) begin
                beat_r <= beat_r + 4'h1;
            end
            if (state_r == DCC_RD && MST_ACK) begin
                data_r <= MST_RDATA;
            end
        end
    end

    // ----------------------------------------------------------------
    // Address and count registers
    // ----------------------------------------------------------------
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            src_r <= 32'h00000000;
            tgt_r <= 32'h00000000;
            cnt_r <= 32'h00000000;
        end else begin
            if (state_r == DCC_STEP) begin
                cnt_r <= cnt_r - 32'h1;
                if (ctl_lo_r[`DCC_LO_SINC]) begin
                    src_r <= src_r + src_step;
                end
                if (ctl_lo_r[`DCC_LO_TINC]) begin
                    tgt_r <= tgt_r + tgt_step;
                end
            end
            if (ld_vld_q && ld_word_q == 2'h1) begin
                src_r <= mem_rdata;
            end
            if (ld_vld_q && ld_word_q == 2'h2) begin
                tgt_r <= mem_rdata;
            end
            if (ld_vld_q && ld_word_q == 2'h3) begin
                cnt_r <= mem_rdata;
            end
            if (wr_q && addr_q == `DCC_OFS_SRC) begin
                src_r <= HWDATA;
            end
            if (wr_q && addr_q == `DCC_OFS_TGT) begin
                tgt_r <= HWDATA;
            end
            if (wr_q && addr_q == `DCC_OFS_CNT) begin
                cnt_r <= HWDATA;
            end
        end
    end

    // ----------------------------------------------------------------
    // System bus master port
    // ----------------------------------------------------------------
    assign BUS_REQ = (state_r == DCC_REQ) || (state_r == DCC_RD) || (state_r == DCC_WR);
    assign MST_REQ = (state_r == DCC_RD) || (state_r == DCC_WR);
    assign MST_WRITE = (state_r == DCC_WR);
    assign MST_WDATA = data_r;

    // Within a burst each beat moves one word past the transaction base.
    always_comb begin
        if (state_r == DCC_WR) begin
            MST_ADDR = ctl_lo_r[`DCC_LO_BURST] ? tgt_r + beat_ofs : tgt_r;
            MST_BE = ctl_lo_r[`DCC_LO_BURST] ? 4'hF : tgt_be;
        end else if (state_r == DCC_RD) begin
            MST_ADDR = ctl_lo_r[`DCC_LO_BURST] ? src_r + beat_ofs : src_r;
            MST_BE = ctl_lo_r[`DCC_LO_BURST] ? 4'hF : src_be;
        end else begin
            MST_ADDR = 32'h00000000;
            MST_BE = 4'h0;
        end
    end
endmodule

// File: hw/dcc_lane_enable.sv
/*
 * Byte enables from access width, low address bits and byte order.
 * Assumes lane 0 carries data bits 7:0.
 */
`timescale 1ns/10ps
module dcc_lane_enable (
    input dcc_pkg::dcc_width_t width,
    input wire logic [1:0] addr,
    input wire logic big,
    output logic [3:0] be
);
    import dcc_pkg::*;

    logic [3:0] le;

    always_comb begin
        case (width)
            DCC_W_BYTE: le = 4'h1 << addr;
            DCC_W_HALF: le = addr[1] ? 4'hC : 4'h3;
            DCC_W_WORD: le = 4'hF;
            default: le = 4'h0;
        endcase
        be = big ? {le[0], le[1], le[2], le[3]} : le;
    end
endmodule

// File: hw/dcc_link_mem.sv
/*
 * Storage for the four chained link descriptors, four words each.
 * Assumes one write and one read per clock; read data comes from a register.
 */
`timescale 1ns/10ps
module dcc_link_mem (
    input wire logic CLK,
    input wire logic we,
    input wire logic [3:0] waddr,
    input wire logic [31:0] wdata,
    input wire logic [3:0] raddr,
    output logic [31:0] rdata
);
    logic [31:0] mem [0:15];

    always_ff @(posedge CLK) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // A write and a read of the same word in one cycle return the new word.
    always_ff @(posedge CLK) begin
        if (we && waddr == raddr) begin
            rdata <= wdata;
        end else begin
            rdata <= mem[raddr];
        end
    end
endmodule

// File: shared/dcc_defines.svh
/*
 * Register offsets, field positions, reset values and counts of the DMA channel control block.
 * Assumes byte addresses on a 32-bit AHB-Lite register bus, one aligned word per register.
 */
`ifndef DCC_DEFINES_SVH
`define DCC_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses, low eight address bits)
// ----------------------------------------------------------------
`define DCC_OFS_CTL_LO 8'h00
`define DCC_OFS_CTL_HI 8'h04
`define DCC_OFS_SRC 8'h08
`define DCC_OFS_TGT 8'h0C
`define DCC_OFS_CNT 8'h10
`define DCC_OFS_STAT 8'h14
`define DCC_LINK_AREA 2'h1

// ----------------------------------------------------------------
// Transfer control low fields
// ----------------------------------------------------------------
`define DCC_LO_WINT 12
`define DCC_LO_BURST 9
`define DCC_LO_SW 7:6
`define DCC_LO_TW 5:4
`define DCC_LO_SBIG 3
`define DCC_LO_TBIG 2
`define DCC_LO_SINC 1
`define DCC_LO_TINC 0

// ----------------------------------------------------------------
// Chain control high fields
// ----------------------------------------------------------------
`define DCC_HI_HALT 15
`define DCC_HI_END 14
`define DCC_HI_RSVD 13:10
`define DCC_HI_LINK 9:8
`define DCC_HI_LEN 3:0

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define DCC_CTL_LO_RST 16'h0000
`define DCC_CTL_HI_RST 16'hFF00
`define DCC_LEN_CODE_DEF 4'h0
`define DCC_BEATS_DEF 4'h4
`define DCC_LD_LAST 2'h3

`endif

// File: shared/dcc_pkg.sv
/*
 * Types shared by the DMA channel control block.
 * Assumes the constants of dcc_defines.svh.
 */
package dcc_pkg;

    typedef enum logic [2:0] {
        DCC_IDLE = 3'h0,
        DCC_WAIT = 3'h1,
        DCC_REQ = 3'h3,
        DCC_RD = 3'h2,
        DCC_WR = 3'h6,
        DCC_STEP = 3'h7,
        DCC_LOAD = 3'h4
    } dcc_state_t;

    typedef enum logic [1:0] {
        DCC_W_BYTE = 2'h0,
        DCC_W_HALF = 2'h1,
        DCC_W_RSVD = 2'h2,
        DCC_W_WORD = 2'h3
    } dcc_width_t;

endpackage
